/* hdl/dic_pkg.sv */
// Package for the 32-point digital input card: map, fields, resets, timing and state layout
package dic_pkg;
  localparam int unsigned NPTS = 32;
  localparam int unsigned FW = 16;
  localparam int unsigned AW = 12;
  localparam int unsigned TICK_W = 16;
  // Byte addresses, one aligned word each
  localparam logic [11:0] A_POINT_BASE = 12'h000;
  localparam logic [11:0] A_POINT_LAST = 12'h07C;
  localparam logic [11:0] A_FPAGE_BASE = 12'h080;
  localparam logic [11:0] A_FPAGE_LAST = 12'h0FC;
  localparam logic [11:0] A_FIELD_LOW = 12'h080;
  localparam logic [11:0] A_FIELD_HIGH = 12'h084;
  localparam logic [11:0] A_SENSE_LOW = 12'h100;
  localparam logic [11:0] A_SENSE_HIGH = 12'h104;
  localparam logic [11:0] A_BYPASS_LOW = 12'h108;
  localparam logic [11:0] A_BYPASS_HIGH = 12'h10C;
  localparam logic [11:0] A_MASK_LOW = 12'h110;
  localparam logic [11:0] A_MASK_HIGH = 12'h114;
  localparam logic [11:0] A_RECORD_LOW = 12'h118;
  localparam logic [11:0] A_RECORD_HIGH = 12'h11C;
  localparam logic [11:0] A_CONFIG = 12'h120;
  localparam logic [11:0] A_STATE = 12'h124;
  localparam logic [11:0] A_IDENTITY = 12'h128;
  localparam logic [11:0] A_HELD_LOW = 12'h12C;
  localparam logic [11:0] A_HELD_HIGH = 12'h130;
  localparam logic [11:0] A_IRQ_STATUS = 12'h134;
  localparam logic [11:0] A_IRQ_CLEAR = 12'h138;
  localparam logic [11:0] A_IRQ_ENABLE = 12'h13C;
  // Configuration field positions
  localparam int unsigned CFG_EXT_LOW = 0;
  localparam int unsigned CFG_EXT_HIGH = 1;
  localparam int unsigned CFG_EDGE_LOW = 8;
  localparam int unsigned CFG_EDGE_HIGH = 9;
  // Interrupt status bit positions
  localparam int unsigned IRQ_EVT_LOW = 0;
  localparam int unsigned IRQ_EVT_HIGH = 1;
  localparam int unsigned IRQ_LAT_LOW = 2;
  localparam int unsigned IRQ_LAT_HIGH = 3;
  localparam int unsigned NIRQ = 4;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] CARD_ID_DEFAULT = 16'h5A3C; // Arbitrary value
  // Internal measurement strobe period
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned MEAS_PERIOD_NS = 16000;
  localparam int unsigned MEAS_PERIOD_CYC = (MEAS_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  typedef struct packed {
    logic [31:0] din_s1;
    logic [31:0] din_s2;
    logic [31:0] din_prev;
    logic [1:0] stb_s1;
    logic [1:0] stb_s2;
    logic [1:0] stb_prev;
    logic [31:0] sense;
    logic [31:0] bypass;
    logic [31:0] unmask;
    logic [31:0] record;
    logic [1:0] cfg_ext;
    logic [1:0] cfg_rise;
    logic [1:0] waiting;
    logic [31:0] held;
    logic [NIRQ-1:0] irq_stat;
    logic [NIRQ-1:0] irq_en;
    logic [TICK_W-1:0] tick;
    logic [31:0] rdata;
    logic err;
  } dic_state_t;

  typedef struct packed {
    logic [AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dic_apb_req_t;
endpackage

/* hdl/dic_card.sv */
// Digital input card: 32 synchronised points, strobed fields, event recording, APB registers
// Register map (byte addresses, one aligned word each)
//   0x000-0x07C  point levels, one point per word, level in bit 0
//   0x080        low field, points 1 to 16
//   0x084        high field, points 17 to 32
//   0x088-0x0FC  rest of the field page, reads zero, no error
//   0x100/0x104  edge sense, low and high field
//   0x108/0x10C  sense bypass, any change counts
//   0x110/0x114  event unmask
//   0x118/0x11C  event record, cleared by reading
//   0x120        configuration: strobe source and edge
//   0x124        state: field waiting for a strobe
//   0x128        card identity, arbitrary constant
//   0x12C/0x130  held field data, a read re-arms the field
//   0x134        interrupt status, read only
//   0x138        interrupt clear, write one to clear
//   0x13C        interrupt enable
//   Any other address answers with pslverr and reads zero
//
// Bus timing
//   pready is tied high: no wait states
//   Read data is captured at the setup edge into a flop
//   Side effects of reads land at the access edge
//   So a read side effect matches the word returned
//   Back-to-back transfers need no idle cycle
//
// Input path
//   Every point and strobe pin passes two flip-flops
//   A third stage keeps the previous settled level
//   Levels reach the read mux one to two cycles late
//   Pulses shorter than a clock period may be missed
//
// Event detection
//   Bypass set: any change of the point is an event
//   Else sense set: rising change only
//   Else: falling change only
//   Unmask clear suppresses the point completely
//   A point's first event sets its record bit
//   Further events of a recorded point change nothing
//
// Record clearing
//   A record read clears only the bits it returned
//   An event in the read cycle stays for the next read
//   Such an event raises the field's status bit again
//   Trade-off: one extra interrupt instead of a lost event
//
// Strobed fields
//   After reset both fields sit idle, not armed
//   Reading a held word arms its field
//   The next chosen strobe stores the settled levels
//   Storing disarms the field and sets a status bit
//   Strobes while disarmed are ignored
//   Source per field: external edge or internal tick
//   The internal tick runs freely every MEAS_CYC cycles
//
// Interrupts
//   Status bits 0/1: first event in low or high field
//   Status bits 2/3: low or high field data stored
//   A set in the clearing cycle wins over the clear
//   irq is high while any enabled status bit is set
//
// Reset
//   Asynchronous, active low, all state to zero
//   prdata, pslverr and irq are low during reset
//   The first transfer may start right after release
//
// Configuration word
//   Bit 0 and bit 1: external strobe for low, high field
//   Bit 8 and bit 9: rising edge when set, else falling
//   Other bits are not stored and read zero
//
// Parameters
//   MEAS_CYC: internal tick period in clock cycles
//   CARD_ID: value returned by the identity word
//
// Limitations
//   External strobe edges closer than two cycles merge
//   Unaligned addresses count as unmapped
//   Held read and store in one cycle: the read re-arms
//   A held word read before any strobe returns zero
//   pslverr holds no history: each setup recomputes it
`timescale 1ns/100ps
module dic_card
  import dic_pkg::*;
#(
  parameter int unsigned MEAS_CYC = MEAS_PERIOD_CYC,
  parameter logic [15:0] CARD_ID = CARD_ID_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPTS-1:0] din,
  input wire logic [1:0] ext_strobe,
  output logic irq
);

  // Refuse a period the tick counter cannot hold
  if (MEAS_CYC < 1 || MEAS_CYC > (2 ** TICK_W))
  begin : g_bad_period
    $error("MEAS_CYC out of range");
  end

  // Last count of the free-running tick
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MEAS_CYC - 1);

  // Registered state, its next value and the bundled bus request
  dic_state_t s_q;
  dic_state_t s_d;
  dic_apb_req_t req;

  // Chosen edge of a synchronised strobe
  function automatic logic strobe_edge(input logic prev, input logic cur, input logic rise);
    strobe_edge = rise ? (cur & ~prev) : (~cur & prev);
  endfunction

  // Per-point event: bypass takes any change, else sense picks the direction
  function automatic logic [15:0] field_events(input logic [15:0] prev, input logic [15:0] cur,
                                               input logic [15:0] sen, input logic [15:0] byp,
                                               input logic [15:0] msk);
    logic [15:0] chg;
    chg = prev ^ cur;
    field_events = msk & chg & (byp | (sen & cur) | (~sen & ~cur));
  endfunction

  // Read mux, evaluated in the setup phase so the data comes from a flop
  function automatic logic [32:0] read_word(input dic_state_t s, input logic [AW-1:0] a,
                                            input logic [15:0] id);
    logic [31:0] v;
    logic bad;
    v = RST_WORD;
    bad = 1'b0;
    if (a <= A_POINT_LAST && a[1:0] == 2'b00)
    begin
      v[0] = s.din_s2[a[6:2]];
    end
    else if (a >= A_FPAGE_BASE && a <= A_FPAGE_LAST && a[1:0] == 2'b00)
    begin
      if (a == A_FIELD_LOW)
        v[15:0] = s.din_s2[15:0];
      else if (a == A_FIELD_HIGH)
        v[15:0] = s.din_s2[31:16];
    end
    else
    begin
      case (a)
        A_SENSE_LOW: v[15:0] = s.sense[15:0];
        A_SENSE_HIGH: v[15:0] = s.sense[31:16];
        A_BYPASS_LOW: v[15:0] = s.bypass[15:0];
        A_BYPASS_HIGH: v[15:0] = s.bypass[31:16];
        A_MASK_LOW: v[15:0] = s.unmask[15:0];
        A_MASK_HIGH: v[15:0] = s.unmask[31:16];
        A_RECORD_LOW: v[15:0] = s.record[15:0];
        A_RECORD_HIGH: v[15:0] = s.record[31:16];
        A_CONFIG:
        begin
          v[CFG_EXT_LOW] = s.cfg_ext[0];
          v[CFG_EXT_HIGH] = s.cfg_ext[1];
          v[CFG_EDGE_LOW] = s.cfg_rise[0];
          v[CFG_EDGE_HIGH] = s.cfg_rise[1];
        end
        A_STATE: v[1:0] = s.waiting;
        A_IDENTITY: v[15:0] = id;
        A_HELD_LOW: v[15:0] = s.held[15:0];
        A_HELD_HIGH: v[15:0] = s.held[31:16];
        A_IRQ_STATUS: v[NIRQ-1:0] = s.irq_stat;
        A_IRQ_CLEAR: v = RST_WORD;
        A_IRQ_ENABLE: v[NIRQ-1:0] = s.irq_en;
        default: bad = 1'b1;
      endcase
    end
    read_word = {bad, v};
  endfunction

  // Bus request bundled for the next-state logic
  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};

  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.err & psel & penable;
  assign irq = |(s_q.irq_stat & s_q.irq_en);

  // Next-state logic for the whole card
  always_comb
  begin
    logic [15:0] ev_lo;
    logic [15:0] ev_hi;
    logic [1:0] stb;
    logic tick;
    logic setup;
    logic wr;
    logic rd;
    logic [32:0] rw;
    logic [NIRQ-1:0] irq_set;
    logic [NIRQ-1:0] irq_clr;
    ev_lo = '0;
    ev_hi = '0;
    stb = '0;
    tick = 1'b0;
    setup = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rw = '0;
    irq_set = '0;
    irq_clr = '0;
    // Hold everything unless a path below changes it
    s_d = s_q;

    // Two-stage synchronisers; only the second stage and the previous-level stage are looked at
    s_d.din_s1 = din;
    s_d.din_s2 = s_q.din_s1;
    s_d.din_prev = s_q.din_s2;
    s_d.stb_s1 = ext_strobe;
    s_d.stb_s2 = s_q.stb_s1;
    s_d.stb_prev = s_q.stb_s2;

    // Free-running internal measurement strobe
    tick = (s_q.tick == TICK_LAST);
    s_d.tick = tick ? '0 : s_q.tick + 1'b1;

    // Strobe per field: external edge when enabled, else the internal tick
    stb[0] = s_q.cfg_ext[0] ? strobe_edge(s_q.stb_prev[0], s_q.stb_s2[0], s_q.cfg_rise[0]) : tick;
    stb[1] = s_q.cfg_ext[1] ? strobe_edge(s_q.stb_prev[1], s_q.stb_s2[1], s_q.cfg_rise[1]) : tick;

    // Event detection on settled levels
    ev_lo = field_events(s_q.din_prev[15:0], s_q.din_s2[15:0], s_q.sense[15:0],
                         s_q.bypass[15:0], s_q.unmask[15:0]);
    ev_hi = field_events(s_q.din_prev[31:16], s_q.din_s2[31:16], s_q.sense[31:16],
                         s_q.bypass[31:16], s_q.unmask[31:16]);
    // Bus phases
    setup = psel & ~penable;
    wr = req.psel & req.penable & req.pwrite;
    rd = req.psel & req.penable & ~req.pwrite;
    if (setup)
    begin
      rw = read_word(s_q, req.paddr, CARD_ID);
      s_d.rdata = rw[31:0];
      s_d.err = rw[32];
    end

    // Recording: clear only what the read returned, so a late event stays for the next read
    s_d.record = s_q.record;
    if (rd && req.paddr == A_RECORD_LOW)
    begin
      s_d.record[15:0] = s_q.record[15:0] & ~s_q.rdata[15:0];
      irq_clr[IRQ_EVT_LOW] = 1'b1;
    end
    if (rd && req.paddr == A_RECORD_HIGH)
    begin
      s_d.record[31:16] = s_q.record[31:16] & ~s_q.rdata[15:0];
      irq_clr[IRQ_EVT_HIGH] = 1'b1;
    end
    // Only a point's first event raises the flip-flop; judged after clearing so a kept event interrupts
    irq_set[IRQ_EVT_LOW] = |(ev_lo & ~s_d.record[15:0]);
    irq_set[IRQ_EVT_HIGH] = |(ev_hi & ~s_d.record[31:16]);
    s_d.record = s_d.record | {ev_hi, ev_lo};

    // Held data: a strobe stores only while armed, a held read consumes and re-arms
    for (int f = 0; f < 2; f++)
    begin
      if (s_q.waiting[f] && stb[f])
      begin
        s_d.held[f*FW +: FW] = s_q.din_s2[f*FW +: FW];
        s_d.waiting[f] = 1'b0;
        irq_set[IRQ_LAT_LOW + f] = 1'b1;
      end
    end
    if (rd && req.paddr == A_HELD_LOW)
      s_d.waiting[0] = 1'b1;
    if (rd && req.paddr == A_HELD_HIGH)
      s_d.waiting[1] = 1'b1;

    // Register writes
    if (wr)
    begin
      case (req.paddr)
        A_SENSE_LOW: s_d.sense[15:0] = req.pwdata[15:0];
        A_SENSE_HIGH: s_d.sense[31:16] = req.pwdata[15:0];
        A_BYPASS_LOW: s_d.bypass[15:0] = req.pwdata[15:0];
        A_BYPASS_HIGH: s_d.bypass[31:16] = req.pwdata[15:0];
        A_MASK_LOW: s_d.unmask[15:0] = req.pwdata[15:0];
        A_MASK_HIGH: s_d.unmask[31:16] = req.pwdata[15:0];
        A_CONFIG:
        begin
          // Undefined bits are not stored
          s_d.cfg_ext = {req.pwdata[CFG_EXT_HIGH], req.pwdata[CFG_EXT_LOW]};
          s_d.cfg_rise = {req.pwdata[CFG_EDGE_HIGH], req.pwdata[CFG_EDGE_LOW]};
        end
        A_IRQ_CLEAR: irq_clr = irq_clr | req.pwdata[NIRQ-1:0];
        A_IRQ_ENABLE: s_d.irq_en = req.pwdata[NIRQ-1:0];
        default: ;
      endcase
    end

    // Sticky status; a set in the clearing cycle wins
    s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
  end

  // One register bank for all state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

/* verification/dic_card_props.sv */
// Port assertions for the digital input card
`timescale 1ns/100ps
module dic_card_chk
  import dic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPTS-1:0] din,
  input wire logic [1:0] ext_strobe,
  input wire logic irq
);
  logic rda;
  logic acs;
  // Any access phase
  assign acs = psel && penable;
  // Read access phase, where read data is judged
  assign rda = psel && penable && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_pt;
    rda && paddr <= A_POINT_LAST |-> prdata[31:1] == 31'h0;
  endproperty
  property p_fld;
    rda && (paddr == A_FIELD_LOW || paddr == A_FIELD_HIGH) |-> prdata[31:16] == 16'h0;
  endproperty
  property p_page;
    rda && paddr > A_FIELD_HIGH && paddr <= A_FPAGE_LAST |-> prdata == 32'h0 && !pslverr;
  endproperty
  property p_cfg;
    rda && paddr == A_CONFIG |-> (prdata & 32'hFFFF_FCFC) == 32'h0;
  endproperty
  property p_st;
    rda && paddr == A_STATE |-> prdata[31:2] == 30'h0;
  endproperty
  // Interrupt enable cleared means the line must drop at once
  property p_ien;
    psel && penable && pwrite && paddr == A_IRQ_ENABLE && pwdata[NIRQ-1:0] == '0 |=> !irq;
  endproperty
  // The line only falls as a result of a bus access
  property p_fall;
    $fell(irq) |-> $past(acs);
  endproperty
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_pt: assert property (p_pt) else $error("point read upper bits set");
  a_fld: assert property (p_fld) else $error("field read upper bits set");
  a_page: assert property (p_page) else $error("field page hole not empty");
  a_cfg: assert property (p_cfg) else $error("undefined config bits read back");
  a_st: assert property (p_st) else $error("state meaningless bits set");
  a_ien: assert property (p_ien) else $error("irq with enable clear");
  a_fall: assert property (p_fall) else $error("irq fell without access");
  a_err: assert property (p_err) else $error("error outside access");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_cfg: cover property (rda && paddr == A_CONFIG);
endmodule
bind dic_card dic_card_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .din, .ext_strobe, .irq);

/* verification/dic_host_bfm.sv */
// Processor-side model issuing APB transfers to the card
`timescale 1ns/100ps
module dic_host_bfm
  import dic_pkg::*;
(
  input wire logic pclk,
  output logic [AW-1:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // Setup, then access held until pready is seen at a rising edge; bounded wait
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic er, output logic to);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    rd = prdata;
    er = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd; // Stale data must not look valid
  endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the digital input card
`timescale 1ns/100ps
module tb_top
  import dic_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } dic_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, to;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [NPTS-1:0] din;
  logic [1:0] ext_strobe;
  int n_fail, samples_checked;
  dic_row_t rows [8];
  // Short strobe period keeps the run brief
  dic_card #(.MEAS_CYC(8)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .din, .ext_strobe, .irq);
  dic_host_bfm u_host (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // A hung transfer ends the run at once
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd);
    u_host.xfer(w, a, wd, rdv, er, to);
    if (to)
    begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // Irq is decoded from registered state, so look at it mid-cycle
  task automatic ck_irq(input logic e);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic hold(input logic [31:0] d, input logic [1:0] s);
    din <= d;
    ext_strobe <= s;
    repeat (6) @(posedge pclk);
  endtask
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    presetn = 1'b0;
    din = 32'h0;
    ext_strobe = 2'h0;
    rows[0] = '{12'h000, 32'h0000_0001, 32'h1};
    rows[1] = '{12'h07C, 32'h8000_0000, 32'h1};
    rows[2] = '{12'h004, 32'hFFFF_FFFD, 32'h0};
    rows[3] = '{A_FIELD_LOW, 32'h1234_ABCD, 32'h0000_ABCD};
    rows[4] = '{A_FIELD_HIGH, 32'h1234_ABCD, 32'h0000_1234};
    rows[5] = '{12'h088, 32'hFFFF_FFFF, 32'h0};
    rows[6] = '{A_CONFIG, 32'h0, 32'h0};
    rows[7] = '{A_IDENTITY, 32'h0, {16'h0, CARD_ID_DEFAULT}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      hold(rows[i].d, 2'h0);
      rd(rows[i].a, rows[i].e);
    end
    // Events: point 1 any change, point 2 rising only
    hold(32'h0, 2'h0);
    acc(1'b1, A_MASK_LOW, 32'hFFFF);
    acc(1'b1, A_BYPASS_LOW, 32'h1);
    acc(1'b1, A_SENSE_LOW, 32'h2);
    acc(1'b1, A_IRQ_ENABLE, 32'h1);
    hold(32'h3, 2'h0);
    ck_irq(1'b1);
    rd(A_RECORD_LOW, 32'h3);
    ck_irq(1'b0);
    rd(A_RECORD_LOW, 32'h0);
    hold(32'h0, 2'h0);
    rd(A_RECORD_LOW, 32'h1);
    // External strobes: field one rising, field two falling
    acc(1'b1, A_IRQ_ENABLE, 32'h4);
    acc(1'b1, A_CONFIG, 32'hFFFF_FFFF);
    rd(A_CONFIG, 32'h303);
    acc(1'b1, A_CONFIG, 32'h103);
    rd(A_HELD_LOW, 32'h0);
    rd(A_HELD_HIGH, 32'h0);
    rd(A_STATE, 32'h3);
    hold(32'h1111_2222, 2'h0);
    hold(32'h1111_2222, 2'h3);
    hold(32'h3333_4444, 2'h3);
    hold(32'h3333_4444, 2'h0);
    rd(A_STATE, 32'h0);
    hold(32'h5555_6666, 2'h3);
    hold(32'h5555_6666, 2'h0);
    ck_irq(1'b1);
    rd(A_HELD_LOW, 32'h2222);
    rd(A_HELD_HIGH, 32'h3333);
    acc(1'b1, A_IRQ_ENABLE, 32'h0);
    ck_irq(1'b0);
    acc(1'b0, 12'h200, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Second reset restores register defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CONFIG, 32'h0);
    summarize();
  end
endmodule
